//--- adc_overrange_detector.sv
// Overrange detector: magnitude compare against two thresholds, hold-stretched flags.
// Assumes samples arrive one per channel per sys_clk_i cycle with a valid strobe.
//
// How it works
// - Magnitude of each sample compared to two thresholds.
// - Both channels share the same threshold pair.
// - Magnitude folds signed code per the table.
// - Flag set when magnitude reaches threshold.
// - Separate high and low flags per channel.
// - Flag holds 8 to 1024 cycles after event.
`timescale 1ns/1ps
`include "ovr_defs.svh"
module adc_overrange_detector (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic sample_valid_i,
  input wire logic [`OVR_SAMPLE_W-1:0] chan_a_sample_i,
  input wire logic [`OVR_SAMPLE_W-1:0] chan_b_sample_i,
  input wire ovr_pkg::ovr_cfg_s cfg_i,
  output ovr_pkg::ovr_flags_s flags_o
);
  // ----------------------------------------
  // Configuration fields
  // ----------------------------------------
  logic [`OVR_SAMPLE_W-1:0] high_thr;
  logic [`OVR_SAMPLE_W-1:0] low_thr;
  logic [`OVR_SEL_W-1:0] hold_sel;

  // Used live: a new setting applies from the next sample on
  assign high_thr = cfg_i.high_threshold;

  assign low_thr = cfg_i.low_threshold;

  assign hold_sel = cfg_i.flag_hold_select;

  // ----------------------------------------
  // Magnitude folding
  // ----------------------------------------
  logic [`OVR_SAMPLE_W-1:0] mag_a;
  logic [`OVR_SAMPLE_W-1:0] mag_b;

  ovr_magnitude u_mag_a (
    .sample_i(chan_a_sample_i),
    .mag_o(mag_a)
  );

  ovr_magnitude u_mag_b (
    .sample_i(chan_b_sample_i),
    .mag_o(mag_b)
  );

  // ----------------------------------------
  // Threshold compare
  // ----------------------------------------
  logic [`OVR_SAMPLE_W-1:0] flag_mag [`OVR_FLAGS];
  logic [`OVR_SAMPLE_W-1:0] flag_thr [`OVR_FLAGS];
  logic [`OVR_FLAGS-1:0] hit;

  // Bit order: 3 a-high, 2 a-low, 1 b-high, 0 b-low
  generate
    for (genvar k = 0; k < `OVR_FLAGS; k++) begin : g_flag
      if (k >= 2) begin : g_chan_a
        assign flag_mag[k] = mag_a;
      end else begin : g_chan_b
        assign flag_mag[k] = mag_b;
      end

      if (k % 2 == 1) begin : g_high
        assign flag_thr[k] = high_thr;
      end else begin : g_low
        assign flag_thr[k] = low_thr;
      end

      // Equal counts as reaching the threshold
      assign hit[k] = sample_valid_i
                      && (flag_mag[k] >= flag_thr[k]);
    end
  endgenerate

  // ----------------------------------------
  // Hold length
  // ----------------------------------------
  ovr_pkg::count_t hold_len;
  ovr_pkg::count_t reload;

  always_comb begin
    case (hold_sel)
      3'h0: begin
        hold_len = `OVR_HOLD_LEN0;
      end

      3'h1: begin
        hold_len = `OVR_HOLD_LEN1;
      end

      3'h2: begin
        hold_len = `OVR_HOLD_LEN2;
      end

      3'h3: begin
        hold_len = `OVR_HOLD_LEN3;
      end

      3'h4: begin
        hold_len = `OVR_HOLD_LEN4;
      end

      3'h5: begin
        hold_len = `OVR_HOLD_LEN5;
      end

      3'h6: begin
        hold_len = `OVR_HOLD_LEN6;
      end

      3'h7: begin
        hold_len = `OVR_HOLD_LEN7;
      end

      default: begin
        hold_len = `OVR_HOLD_LEN0;
      end
    endcase
  end

  // The cycle with the count at zero is the last cycle of the pulse
  assign reload = hold_len - `OVR_CNT_ONE;

  // ----------------------------------------
  // State
  // ----------------------------------------
  ovr_pkg::ovr_state_s state;
  ovr_pkg::ovr_state_s next_state;
  logic [`OVR_FLAGS-1:0] live;

  always_comb begin
    next_state = state;

    for (int i = 0; i < `OVR_FLAGS; i++) begin
      live[i] = (state.cnt[i] != `OVR_CNT_ZERO);
    end

    for (int i = 0; i < `OVR_FLAGS; i++) begin
      if (hit[i]) begin
        // Reload on each event so the hold counts from the latest one
        next_state.cnt[i] = reload;
        next_state.flag[i] = 1'b1;
      end else if (live[i]) begin
        next_state.cnt[i] = state.cnt[i] - `OVR_CNT_ONE;
        next_state.flag[i] = 1'b1;
      end else begin
        next_state.cnt[i] = `OVR_CNT_ZERO;
        next_state.flag[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Flag outputs
  // ----------------------------------------
  // Single-channel use leaves the OR of a/b flags to the downstream logic
  assign flags_o.chan_a_high_flag = state.flag[3];

  assign flags_o.chan_a_low_flag = state.flag[2];

  assign flags_o.chan_b_high_flag = state.flag[1];

  assign flags_o.chan_b_low_flag = state.flag[0];

endmodule

//--- ovr_defs.svh
// Constants for the overrange detector: widths, hold lengths, sample codes.
// Assumes inclusion by bare name from the package and modules.
`ifndef OVR_DEFS_SVH
`define OVR_DEFS_SVH
// ----------------------------------------
// Widths
// ----------------------------------------
`define OVR_SAMPLE_W 8
`define OVR_SEL_W 3
`define OVR_CNT_W 11
// ----------------------------------------
// Hold lengths
// ----------------------------------------
`define OVR_HOLD_BASE 11'h008
`define OVR_CNT_ZERO 11'h000
`define OVR_CNT_ONE 11'h001
`define OVR_FLAGS 4
`define OVR_HOLD_LEN0 11'h008
`define OVR_HOLD_LEN1 11'h010
`define OVR_HOLD_LEN2 11'h020
`define OVR_HOLD_LEN3 11'h040
`define OVR_HOLD_LEN4 11'h080
`define OVR_HOLD_LEN5 11'h100
`define OVR_HOLD_LEN6 11'h200
`define OVR_HOLD_LEN7 11'h400
// ----------------------------------------
// Sample codes
// ----------------------------------------
`define OVR_CODE_MIN 8'h80
`define OVR_CODE_ZERO 8'h00
`define OVR_MAG_FULL 8'hff
`endif

//--- ovr_pkg.sv
// Types shared by the overrange detector modules.
// Assumes ovr_defs.svh is on the include path.
`include "ovr_defs.svh"
package ovr_pkg;
  typedef logic [`OVR_SAMPLE_W-1:0] sample_t;
  typedef logic [`OVR_CNT_W-1:0] count_t;
  typedef struct packed {
    sample_t high_threshold;
    sample_t low_threshold;
    logic [`OVR_SEL_W-1:0] flag_hold_select;
  } ovr_cfg_s;
  typedef struct packed {
    logic chan_a_high_flag;
    logic chan_a_low_flag;
    logic chan_b_high_flag;
    logic chan_b_low_flag;
  } ovr_flags_s;
  typedef struct packed {
    count_t [`OVR_FLAGS-1:0] cnt;
    logic [`OVR_FLAGS-1:0] flag;
  } ovr_state_s;
endpackage

//--- ovr_magnitude.sv
// Folds a signed 8-bit sample into its 8-bit comparison magnitude.
// Assumes two's complement input; purely combinational.
`timescale 1ns/1ps
`include "ovr_defs.svh"
module ovr_magnitude (
  input wire logic [`OVR_SAMPLE_W-1:0] sample_i,
  output logic [`OVR_SAMPLE_W-1:0] mag_o
);
  logic [`OVR_SAMPLE_W-1:0] negated;

  // Negative codes fold to twice their size, so -127 -> 254; -128 has no positive twin
  always_comb begin
    negated = `OVR_CODE_ZERO - sample_i;
    if (sample_i == `OVR_CODE_MIN) begin
      mag_o = `OVR_MAG_FULL;
    end else if (sample_i[`OVR_SAMPLE_W-1]) begin
      mag_o = {negated[`OVR_SAMPLE_W-2:0], 1'b0};
    end else if (sample_i == `OVR_CODE_ZERO) begin
      mag_o = 8'h00;
    end else begin
      mag_o = {sample_i[`OVR_SAMPLE_W-2:0], 1'b1};
    end
  end
endmodule

//--- ovr_props.sv
// Port checker for the overrange detector, bound from the testbench top file.
`timescale 1ns/1ps
module ovr_props (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic sample_valid_i,
  input wire logic [7:0] chan_a_sample_i,
  input wire logic [7:0] chan_b_sample_i,
  input wire ovr_pkg::ovr_cfg_s cfg_i,
  input wire ovr_pkg::ovr_flags_s flags_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire v = sample_valid_i;
  sequence s_quiet; (!v && cfg_i.flag_hold_select == 3'h0) [*8]; endsequence
  property p_pos; v && chan_b_sample_i == 8'h7f |=> flags_o[1:0] == 2'b11; endproperty
  a_pos: assert property (p_pos) else $error("full scale missed");
  property p_fold; v && chan_a_sample_i == 8'h80 |=> flags_o[3:2] == 2'b11; endproperty
  a_fold: assert property (p_fold) else $error("min code missed");
  property p_neg; v && chan_b_sample_i == 8'h81 && cfg_i.high_threshold == 8'hff && !flags_o[1] |=> !flags_o[1]; endproperty
  a_neg: assert property (p_neg) else $error("code 81 folded high");
  property p_zero; v && chan_a_sample_i == 8'h00 && cfg_i.low_threshold != 8'h00 && !flags_o[2] |=> !flags_o[2]; endproperty
  a_zero: assert property (p_zero) else $error("zero raised flag");
  property p_stand; v && chan_a_sample_i == 8'h80 |=> flags_o[3] [*8]; endproperty
  a_stand: assert property (p_stand) else $error("flag dropped early");
  property p_drop; v && chan_a_sample_i == 8'h80 && cfg_i.flag_hold_select == 3'h0 ##1 s_quiet |=> !flags_o[3]; endproperty
  a_drop: assert property (p_drop) else $error("flag held too long");
  property p_rst; $fell(sys_rst_i) |-> flags_o == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("flag set after reset");
endmodule

//--- ovr_gain_ctl.sv
// Downstream gain logic on the flag pins; shares the detector clock.
`timescale 1ns/1ps
module ovr_gain_ctl (
  input wire logic clk_i,
  input wire ovr_pkg::ovr_flags_s flags_i,
  output logic [3:0] gain_o = 4'h8
);
  logic [9:0] quiet = 10'h000;
  always_ff @(posedge clk_i) begin
    quiet <= flags_i[2] | flags_i[0] ? 10'h000 : quiet + 10'h001;
    if (flags_i[3] | flags_i[1])
      gain_o <= gain_o - 4'h1;
    else if (&quiet)
      gain_o <= gain_o + 4'h1;
  end
endmodule

//--- adc_overrange_detector_tb.sv
// Self-checking bench; package, design, checker and far-side model compile first.
`timescale 1ns/1ps
module adc_overrange_detector_tb;
  logic clk = 0, rst = 1, v = 0;
  logic [7:0] a = 8'h00, b = 8'h00;
  logic [31:0] sd = 32'h8ce1b7ee;
  logic [10:0] cnt [4];
  ovr_pkg::ovr_cfg_s cfg = {8'hff, 8'h40, 3'h0};
  ovr_pkg::ovr_flags_s f;
  int failures = 0, cmp_count = 0;
  adc_overrange_detector dut (.sys_clk_i(clk), .sys_rst_i(rst), .sample_valid_i(v),
    .chan_a_sample_i(a), .chan_b_sample_i(b), .cfg_i(cfg), .flags_o(f));
  ovr_gain_ctl far (.clk_i(clk), .flags_i(f), .gain_o());
  initial forever #25 clk = ~clk;
  function automatic logic [7:0] mg(logic [7:0] s);
    return s[7] ? (s == 8'h80 ? 8'hff : {7'(-s), 1'b0}) : (s == 8'h00 ? 8'h00 : {s[6:0], 1'b1});
  endfunction
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    return (x ^ (x >> 17)) ^ ((x ^ (x >> 17)) << 5);
  endfunction
  task automatic chk(logic [3:0] g, logic [3:0] e);
    cmp_count++;
    failures += (g !== e) || cmp_count > 20000;
    if (g !== e) $display("wrong value at %0t: flags %h not %h", $time, g, e);
    if (cmp_count > 20000) stop_test();
  endtask
  task stop_test;
    $display("%0d compares, %0d failures", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hold restarts on every hit, counts down otherwise
  always @(posedge clk)
    for (int i = 0; i < 4; i++)
      cnt[i] <= rst ? 11'h000 : v && mg(i > 1 ? a : b) >= (i[0] ? cfg[18:11] : cfg[10:3]) ?
        11'h008 << cfg[2:0] : cnt[i] - 11'(cnt[i] != 11'h000);
  always @(negedge clk) chk(f, {cnt[3] != 0, cnt[2] != 0, cnt[1] != 0, cnt[0] != 0});
  initial begin
    repeat (4) @(negedge clk);
    rst = 0;
    @(negedge clk) {v, a, b} = {1'b1, 8'h00, 8'h81};
    @(negedge clk) {v, a, b} = {1'b1, 8'h80, 8'h7f};
    for (int s = 0; s < 8; s++) begin
      repeat (1040) @(negedge clk) {v, a, b} = 17'h00000;
      cfg[2:0] = 3'(s);
      @(negedge clk) {v, a, b} = {1'b1, 8'h80, 8'h00};
    end
    // Random traffic with live config changes and rare mid-run resets
    repeat (3000) begin
      sd = xs(sd);
      rst = sd[12:6] == 7'h00;
      cfg = sd[3:0] == 4'h0 ? sd[31:13] : cfg;
      @(negedge clk) {v, a, b} = sd[16:0];
    end
    stop_test();
  end
endmodule
bind adc_overrange_detector ovr_props props (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .sample_valid_i(sample_valid_i),
  .chan_a_sample_i(chan_a_sample_i), .chan_b_sample_i(chan_b_sample_i), .cfg_i(cfg_i), .flags_o(flags_o));
